// file: verilog/mfo_top.sv
// multifunction output selector: apb settings, conditions, three terminals
//
// Local design decisions: the register offsets and the APB slave port.
module mfo_top #(
  parameter int CYC_PER_MS = mfo_pkg::CYC_PER_MS_DEF
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [mfo_pkg::FW-1:0] freq_out,
  input logic [mfo_pkg::FW-1:0] freq_ref,
  input logic [mfo_pkg::FW-1:0] current,
  input logic [mfo_pkg::FW-1:0] dc_bus,
  input logic run_cmd,
  input logic fault_active,
  input logic comm_error_a,
  input logic comm_error_b,
  input logic auto_restart,
  input logic base_block,
  input logic over_torque,
  input logic low_torque,
  input logic plc_contact,
  input logic drive_ready,
  input logic local_sel,
  input logic ref_loss,
  input logic trav_up,
  input logic trav_on,
  input logic motor2_sel,
  input logic zero_servo_lock,
  input logic pos_done,
  input logic pid_fb_loss,
  output logic digital_out_a,
  output logic digital_out_b,
  output logic digital_out_c,
  output logic run_source_lamp,
  output logic ref_source_lamp,
  output logic loss_resp,
  output logic [7:0] loss_ratio
);
  import mfo_pkg::*;

  mfo_st_t st_r;
  mfo_st_t st_nxt;
  mfo_cond_if cif ();

  logic [NOUT-1:0] dout;
  logic wr_en;
  logic all_comm;
  logic [FW:0] lvl_hi;
  logic local_run;
  logic local_ref;

  // address decode shared by the write enable and the error answer
  function automatic logic addr_hit(input logic [7:0] a);
    unique case (a)
      A_FUNC_A, A_FUNC_B, A_FUNC_C, A_DET_LVL, A_DET_WID, A_CUR_THR,
      A_CUR_TIME, A_FMIN, A_RUN_SRC, A_REF_SRC, A_RELAY, A_LOSS_CFG,
      A_STATUS, A_UV_LVL: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // apb: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign wr_en = psel & penable & pwrite & addr_hit(paddr);

  assign lvl_hi = {1'b0, st_r.lvl} + {1'b0, st_r.wid};
  assign local_run = (st_r.run_src == SRC_LOCAL) | local_sel;
  assign local_ref = (st_r.ref_src == SRC_LOCAL) | local_sel;
  assign all_comm = (st_r.func[0] == FN_COMM) & (st_r.func[1] == FN_COMM)
                  & (st_r.func[2] == FN_COMM);

  always_comb begin
    st_nxt = st_r;
    if (psel && !penable) begin
      st_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        A_FUNC_A: st_nxt.prdata[CW-1:0] = st_r.func[0];
        A_FUNC_B: st_nxt.prdata[CW-1:0] = st_r.func[1];
        A_FUNC_C: st_nxt.prdata[CW-1:0] = st_r.func[2];
        A_DET_LVL: st_nxt.prdata[FW-1:0] = st_r.lvl;
        A_DET_WID: st_nxt.prdata[FW-1:0] = st_r.wid;
        A_CUR_THR: st_nxt.prdata[FW-1:0] = st_r.cthr;
        A_CUR_TIME: st_nxt.prdata[FW-1:0] = st_r.ctime;
        A_FMIN: st_nxt.prdata[FW-1:0] = st_r.fmin;
        A_UV_LVL: st_nxt.prdata[FW-1:0] = st_r.uvl;
        A_RUN_SRC: st_nxt.prdata[1:0] = st_r.run_src;
        A_REF_SRC: st_nxt.prdata[1:0] = st_r.ref_src;
        A_RELAY: st_nxt.prdata[2:0] = st_r.relay;
        A_LOSS_CFG: begin
          st_nxt.prdata[LOSS_RESP_BIT] = st_r.loss_resp;
          st_nxt.prdata[LOSS_RATIO_LSB +: 8] = st_r.loss_ratio;
        end
        A_STATUS: begin
          st_nxt.prdata[ST_OUT_LSB +: NOUT] = dout;
          st_nxt.prdata[ST_FDET_BIT] = st_r.fdet;
          st_nxt.prdata[ST_CUR_BIT] = st_r.cur_ok;
          st_nxt.prdata[ST_RUN_LAMP_BIT] = st_r.run_lamp;
          st_nxt.prdata[ST_REF_LAMP_BIT] = st_r.ref_lamp;
        end
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        A_FUNC_A: st_nxt.func[0] = pwdata[CW-1:0];
        A_FUNC_B: st_nxt.func[1] = pwdata[CW-1:0];
        A_FUNC_C: st_nxt.func[2] = pwdata[CW-1:0];
        A_DET_LVL: st_nxt.lvl = pwdata[FW-1:0];
        A_DET_WID: st_nxt.wid = pwdata[FW-1:0];
        A_CUR_THR: st_nxt.cthr = pwdata[FW-1:0];
        A_CUR_TIME: st_nxt.ctime = pwdata[FW-1:0];
        A_FMIN: st_nxt.fmin = pwdata[FW-1:0];
        A_UV_LVL: st_nxt.uvl = pwdata[FW-1:0];
        A_RUN_SRC: st_nxt.run_src = pwdata[1:0];
        A_REF_SRC: st_nxt.ref_src = pwdata[1:0];
        A_RELAY: st_nxt.relay = pwdata[2:0];
        A_LOSS_CFG: begin
          st_nxt.loss_resp = pwdata[LOSS_RESP_BIT];
          st_nxt.loss_ratio = pwdata[LOSS_RATIO_LSB +: 8];
        end
        default: st_nxt.lvl = st_r.lvl;
      endcase
    end
    if ({1'b0, freq_out} > lvl_hi) begin
      st_nxt.fdet = 1'b1;
    end else if (freq_out < st_r.lvl) begin
      st_nxt.fdet = 1'b0;
    end
    if (current > st_r.cthr) begin
      if (st_r.pre == 16'(CYC_PER_MS - 1)) begin
        st_nxt.pre = 16'h0000;
        if (st_r.ms != 16'hffff) begin
          st_nxt.ms = st_r.ms + 16'h0001;
        end
      end else begin
        st_nxt.pre = st_r.pre + 16'h0001;
      end
    end else begin
      st_nxt.pre = 16'h0000;
      st_nxt.ms = 16'h0000;
    end
    st_nxt.cur_ok = (current > st_r.cthr) && (st_r.ms > st_r.ctime);
    st_nxt.run_lamp = ~local_run;
    st_nxt.ref_lamp = ~local_ref;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.func <= {NOUT{FUNC_RST}};
      st_r.lvl <= WORD_RST;
      st_r.wid <= WORD_RST;
      st_r.cthr <= WORD_RST;
      st_r.ctime <= WORD_RST;
      st_r.fmin <= WORD_RST;
      st_r.uvl <= WORD_RST;
      st_r.run_src <= SRC_RST;
      st_r.ref_src <= SRC_RST;
      st_r.relay <= RELAY_RST;
      st_r.loss_ratio <= RATIO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // condition vector, indexed by function code; unlisted codes stay low
  always_comb begin
    cif.cond = '0;
    cif.cond[FN_RUNNING] = run_cmd | (freq_out != 16'h0000);
    cif.cond[FN_FAULT] = fault_active & ~comm_error_a & ~comm_error_b;
    cif.cond[FN_FREQ_AGREE] = (freq_out <= freq_ref)
      && (({1'b0, freq_out} + {1'b0, st_r.wid}) >= {1'b0, freq_ref});
    cif.cond[FN_SET_AGREE] = ({1'b0, freq_out} <= lvl_hi)
      && (({1'b0, freq_out} + {1'b0, st_r.wid}) >= {1'b0, st_r.lvl});
    cif.cond[FN_FDET1] = st_r.fdet;
    cif.cond[FN_FDET2] = ~st_r.fdet;
    cif.cond[FN_RESTART] = auto_restart;
    cif.cond[FN_BASEBLOCK] = base_block;
    cif.cond[FN_OVER_TQ] = over_torque;
    cif.cond[FN_LOW_TQ] = low_torque;
    cif.cond[FN_CUR_AGREE] = st_r.cur_ok;
    cif.cond[FN_PLC_STAT] = st_r.run_src == SRC_PLC;
    cif.cond[FN_PLC_CTRL] = plc_contact;
    cif.cond[FN_ZERO_SPD] = freq_out > st_r.fmin;
    cif.cond[FN_READY] = drive_ready & ~fault_active;
    cif.cond[FN_UNDERVOLT] = dc_bus < st_r.uvl;
    cif.cond[FN_RUN_LOCAL] = local_run;
    cif.cond[FN_REF_LOCAL] = local_ref;
    cif.cond[FN_REF_LOSS] = ref_loss;
    cif.cond[FN_TRAV_UP] = trav_up;
    cif.cond[FN_TRAV_ON] = trav_on;
    cif.cond[FN_MOTOR2] = motor2_sel;
    cif.cond[FN_ZERO_SERVO] = zero_servo_lock;
    cif.cond[FN_PID_LOSS] = pid_fb_loss;
    cif.cond[FN_POS_AGREE] = pos_done;
  end

  generate
    for (genvar i = 0; i < NOUT; i++) begin : g_sel
      mfo_out_sel u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .cb(cif.sel),
        .code(st_r.func[i]),
        .relay_bit(st_r.relay[i]),
        // upper bits need all three on comm and the key word
        .relay_en((i == 0) | (all_comm & (st_r.relay == RELAY_ALL_KEY))),
        .dout(dout[i])
      );
    end
  endgenerate

  assign digital_out_a = dout[0];
  assign digital_out_b = dout[1];
  assign digital_out_c = dout[2];
  assign run_source_lamp = st_r.run_lamp;
  assign ref_source_lamp = st_r.ref_lamp;
  assign loss_resp = st_r.loss_resp;
  assign loss_ratio = st_r.loss_ratio;
  assign prdata = st_r.prdata;

  ////////////////////////////////////////////////////////////////
  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  run_out_a: assert property (
    st_r.func[0] == FN_RUNNING && !wr_en && (run_cmd || freq_out != 16'h0000)
    |=> digital_out_a)
    else $error("running output missing");

  fault_mask_a: assert property (
    st_r.func[0] == FN_FAULT && !wr_en && comm_error_a |=> !digital_out_a)
    else $error("comm error raised fault output");

  fdet_hyst_a: assert property (
    {1'b0, freq_out} > lvl_hi |=> st_r.fdet)
    else $error("detection flag not set above band");

  fdet_hold_a: assert property (
    freq_out >= st_r.lvl && {1'b0, freq_out} <= lvl_hi && !wr_en
    |=> st_r.fdet == $past(st_r.fdet))
    else $error("detection flag changed inside band");

  cur_low_a: assert property (
    current <= st_r.cthr |=> !st_r.cur_ok && st_r.ms == 16'h0000)
    else $error("current agree with current under threshold");

  plc_src_a: assert property (
    st_r.func[2] == FN_PLC_STAT && st_r.run_src == SRC_PLC && !wr_en
    |=> digital_out_c)
    else $error("plc status output missing");

  undervolt_a: assert property (
    st_r.func[0] == FN_UNDERVOLT && dc_bus < st_r.uvl && !wr_en
    |=> digital_out_a)
    else $error("undervoltage output missing");

  run_lamp_a: assert property (
    st_r.run_src != SRC_LOCAL && !local_sel && !wr_en |=> run_source_lamp)
    else $error("remote lamp not shown");

  comm_gate_a: assert property (
    st_r.func[1] == FN_COMM && !all_comm && !wr_en |=> !digital_out_b)
    else $error("relay bit two passed without gate");

  apb_err_a: assert property (
    psel && !penable && !addr_hit(paddr) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  ref_lamp_a: assert property (
    st_r.ref_src != SRC_LOCAL && !local_sel |=> ref_source_lamp)
    else $error("remote reference lamp not shown");

  zero_speed_a: assert property (
    st_r.func[1] == FN_ZERO_SPD && freq_out <= st_r.fmin |=> !digital_out_b)
    else $error("zero speed output on at minimum");

  relay_follow_a: assert property (
    st_r.func[0] == FN_COMM |=> digital_out_a == $past(st_r.relay[0]))
    else $error("first relay bit not followed");

  write_cov: cover property (wr_en && paddr == A_FUNC_A);
  out_rise_cov: cover property ($rose(digital_out_a));
  cur_ok_cov: cover property ($rose(st_r.cur_ok));
  all_comm_cov: cover property (all_comm && st_r.relay == RELAY_ALL_KEY);
  fdet_fall_cov: cover property ($fell(st_r.fdet));

endmodule

// file: inc/mfo_pkg.sv
// constants, codes and state types of the multifunction output selector
package mfo_pkg;

  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  // ms prescale count: exact division, so no rounding question arises
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_NS;

  localparam int FW = 16;
  localparam int CW = 6;
  localparam int NOUT = 3;
  localparam int NCOND = 64;

  // apb byte addresses
  localparam logic [7:0] A_FUNC_A = 8'h00;
  localparam logic [7:0] A_FUNC_B = 8'h04;
  localparam logic [7:0] A_FUNC_C = 8'h08;
  localparam logic [7:0] A_DET_LVL = 8'h0c;
  localparam logic [7:0] A_DET_WID = 8'h10;
  localparam logic [7:0] A_CUR_THR = 8'h14;
  localparam logic [7:0] A_CUR_TIME = 8'h18;
  localparam logic [7:0] A_FMIN = 8'h1c;
  localparam logic [7:0] A_RUN_SRC = 8'h20;
  localparam logic [7:0] A_REF_SRC = 8'h24;
  localparam logic [7:0] A_RELAY = 8'h28;
  localparam logic [7:0] A_LOSS_CFG = 8'h2c;
  localparam logic [7:0] A_STATUS = 8'h30;
  localparam logic [7:0] A_UV_LVL = 8'h34;

  // field positions
  localparam int LOSS_RESP_BIT = 0;
  localparam int LOSS_RATIO_LSB = 8;
  localparam int ST_OUT_LSB = 0;
  localparam int ST_FDET_BIT = 3;
  localparam int ST_CUR_BIT = 4;
  localparam int ST_RUN_LAMP_BIT = 5;
  localparam int ST_REF_LAMP_BIT = 6;

  // reset values
  localparam logic [CW-1:0] FUNC_RST = 6'h3f;
  localparam logic [FW-1:0] WORD_RST = 16'h0000;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [2:0] RELAY_RST = 3'h0;
  localparam logic [7:0] RATIO_RST = 8'h00;

  // setting values
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_PLC = 2'h3;
  localparam logic [2:0] RELAY_ALL_KEY = 3'h5;

  // output function codes
  localparam logic [CW-1:0] FN_RUNNING = 6'h00;
  localparam logic [CW-1:0] FN_FAULT = 6'h01;
  localparam logic [CW-1:0] FN_FREQ_AGREE = 6'h02;
  localparam logic [CW-1:0] FN_SET_AGREE = 6'h03;
  localparam logic [CW-1:0] FN_FDET1 = 6'h04;
  localparam logic [CW-1:0] FN_FDET2 = 6'h05;
  localparam logic [CW-1:0] FN_RESTART = 6'h06;
  localparam logic [CW-1:0] FN_BASEBLOCK = 6'h09;
  localparam logic [CW-1:0] FN_OVER_TQ = 6'h0c;
  localparam logic [CW-1:0] FN_CUR_AGREE = 6'h0d;
  localparam logic [CW-1:0] FN_PLC_STAT = 6'h12;
  localparam logic [CW-1:0] FN_PLC_CTRL = 6'h13;
  localparam logic [CW-1:0] FN_ZERO_SPD = 6'h14;
  localparam logic [CW-1:0] FN_READY = 6'h15;
  localparam logic [CW-1:0] FN_UNDERVOLT = 6'h16;
  localparam logic [CW-1:0] FN_RUN_LOCAL = 6'h17;
  localparam logic [CW-1:0] FN_REF_LOCAL = 6'h18;
  localparam logic [CW-1:0] FN_LOW_TQ = 6'h19;
  localparam logic [CW-1:0] FN_REF_LOSS = 6'h1a;
  localparam logic [CW-1:0] FN_TRAV_UP = 6'h1c;
  localparam logic [CW-1:0] FN_TRAV_ON = 6'h1d;
  localparam logic [CW-1:0] FN_MOTOR2 = 6'h1e;
  localparam logic [CW-1:0] FN_ZERO_SERVO = 6'h1f;
  localparam logic [CW-1:0] FN_COMM = 6'h20;
  localparam logic [CW-1:0] FN_PID_LOSS = 6'h25;
  localparam logic [CW-1:0] FN_POS_AGREE = 6'h29;

  typedef struct packed {
    logic [NOUT-1:0][CW-1:0] func;
    logic [FW-1:0] lvl;
    logic [FW-1:0] wid;
    logic [FW-1:0] cthr;
    logic [FW-1:0] ctime;
    logic [FW-1:0] fmin;
    logic [FW-1:0] uvl;
    logic [1:0] run_src;
    logic [1:0] ref_src;
    logic [2:0] relay;
    logic loss_resp;
    logic [7:0] loss_ratio;
    logic [31:0] prdata;
    logic fdet;
    logic [15:0] pre;
    logic [FW-1:0] ms;
    logic cur_ok;
    logic run_lamp;
    logic ref_lamp;
  } mfo_st_t;

  typedef struct packed {
    logic out;
  } mfo_sel_st_t;

endpackage

// file: inc/mfo_cond_if.sv
// condition vector shared between the top and the per-terminal selectors
interface mfo_cond_if;
  import mfo_pkg::*;
  logic [NCOND-1:0] cond;
  modport src (output cond);
  modport sel (input cond);
endinterface

// file: verilog/mfo_out_sel.sv
// one output terminal: picks the condition named by its function code, or the gated relay bit for the comm code
module mfo_out_sel (
  input logic pclk,
  input logic presetn,
  mfo_cond_if.sel cb,
  input logic [mfo_pkg::CW-1:0] code,
  input logic relay_bit,
  input logic relay_en,
  output logic dout
);
  import mfo_pkg::*;

  mfo_sel_st_t st_r;
  mfo_sel_st_t st_nxt;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.out = cb.cond[code];
    if (code == FN_COMM) begin
      st_nxt.out = relay_bit & relay_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.out;

  ////////////////////////////////////////////////////////////////
  sel_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    code != FN_COMM |=> dout == $past(cb.cond[code]))
    else $error("terminal does not follow selected condition");

  sel_unassigned_a: assert property (@(posedge pclk) disable iff (!presetn)
    (code == 6'h07 || code == 6'h21 || code == 6'h3f) |=> !dout)
    else $error("unassigned code drives terminal");

endmodule

// file: bench/mfo_relay_model.sv
// model of the relays wired to the three output terminals
module mfo_relay_model #(
  parameter int DLY = 2
) (
  input logic pclk,
  input logic [2:0] coil,
  output logic [2:0] contact
);
  timeunit 1ns;
  timeprecision 1ns;
  // pickup delay: a contact lags its coil, so the bench must not read it early
  logic [DLY-1:0][2:0] pipe_r;
  // normally open: contact closed only while its coil is driven
  always_ff @(posedge pclk) begin
    pipe_r <= {pipe_r[DLY-2:0], coil};
  end
  assign contact = pipe_r[DLY-1];
endmodule

// file: bench/multifunction_output_selector_tb_top.sv
// self-checking bench of the multifunction output selector
module multifunction_output_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mfo_pkg::*;
  typedef struct packed {
    logic [CW-1:0] code;
    logic [17:0] fl;
    logic ex;
  } mfo_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready;
  logic pslverr;
  logic err_seen;
  logic [FW-1:0] freq_out = 16'h0;
  logic [FW-1:0] freq_ref = 16'h0;
  logic [FW-1:0] current = 16'h0;
  logic [FW-1:0] dc_bus = 16'h0;
  logic [17:0] fl = 18'h0;
  logic [2:0] dout;
  logic [2:0] contact;
  logic run_lamp;
  logic ref_lamp;
  logic l_resp;
  logic [7:0] l_ratio;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  mfo_row_t rows [24] = '{
    '{6'h00, 18'h00001, 1'b1}, '{6'h00, 18'h00000, 1'b0},
    '{6'h01, 18'h00002, 1'b1}, '{6'h01, 18'h00006, 1'b0},
    '{6'h01, 18'h0000a, 1'b0}, '{6'h06, 18'h00010, 1'b1},
    '{6'h09, 18'h00020, 1'b1}, '{6'h0c, 18'h00040, 1'b1},
    '{6'h19, 18'h00080, 1'b1}, '{6'h13, 18'h00100, 1'b1},
    '{6'h15, 18'h00200, 1'b1}, '{6'h15, 18'h00202, 1'b0},
    '{6'h1a, 18'h00800, 1'b1}, '{6'h1c, 18'h01000, 1'b1},
    '{6'h1d, 18'h02000, 1'b1}, '{6'h1e, 18'h04000, 1'b1},
    '{6'h1f, 18'h08000, 1'b1}, '{6'h29, 18'h10000, 1'b1},
    '{6'h25, 18'h20000, 1'b1}, '{6'h07, 18'h3ffff, 1'b0},
    '{6'h21, 18'h3ffff, 1'b0}, '{6'h17, 18'h00000, 1'b1},
    '{6'h18, 18'h00000, 1'b1}, '{6'h12, 18'h00000, 1'b0}
  };

  always #25 pclk = ~pclk;

  mfo_top #(.CYC_PER_MS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .freq_out(freq_out),
    .freq_ref(freq_ref), .current(current), .dc_bus(dc_bus),
    .run_cmd(fl[0]), .fault_active(fl[1]), .comm_error_a(fl[2]),
    .comm_error_b(fl[3]), .auto_restart(fl[4]), .base_block(fl[5]),
    .over_torque(fl[6]), .low_torque(fl[7]), .plc_contact(fl[8]),
    .drive_ready(fl[9]), .local_sel(fl[10]), .ref_loss(fl[11]),
    .trav_up(fl[12]), .trav_on(fl[13]), .motor2_sel(fl[14]),
    .zero_servo_lock(fl[15]), .pos_done(fl[16]), .pid_fb_loss(fl[17]),
    .digital_out_a(dout[0]), .digital_out_b(dout[1]),
    .digital_out_c(dout[2]), .run_source_lamp(run_lamp),
    .ref_source_lamp(ref_lamp), .loss_resp(l_resp), .loss_ratio(l_ratio)
  );

  mfo_relay_model #(.DLY(2)) relay (.pclk(pclk), .coil(dout), .contact(contact));

  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    rdv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, exp);
  endtask

  task automatic funcs(input logic [5:0] a, input logic [5:0] b, input logic [5:0] c);
    wr(A_FUNC_A, 32'(a));
    wr(A_FUNC_B, 32'(b));
    wr(A_FUNC_C, 32'(c));
  endtask

  // covers the two-flop path plus the relay pickup delay
  task automatic settle();
    repeat (6) @(posedge pclk);
    #1;
  endtask

  task automatic fstep(input logic [15:0] f, input logic [2:0] ex);
    @(posedge pclk);
    freq_out <= f;
    settle();
    chk("freq", 32'(dout), 32'(ex));
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("func_a", A_FUNC_A, 32'h3f);
    rd("unmapped", 8'h3c, 32'h0);
    chk("slverr", 32'(err_seen), 32'h1);
    wr(A_LOSS_CFG, 32'h0000ab01);
    rd("loss_cfg", A_LOSS_CFG, 32'h0000ab01);
    chk("loss", 32'({l_resp, l_ratio}), 32'h1ab);
    wr(A_STATUS, 32'h7f);
    rd("status", A_STATUS, 32'h0);
    foreach (rows[i]) begin
      funcs(rows[i].code, rows[i].code, rows[i].code);
      @(posedge pclk);
      fl <= rows[i].fl;
      settle();
      chk("dout", 32'(dout), 32'({3{rows[i].ex}}));
      chk("contact", 32'(contact), 32'({3{rows[i].ex}}));
    end
    @(posedge pclk);
    fl <= 18'h0;
    // hysteresis band 100..110, agree window +-10
    wr(A_DET_LVL, 32'h64);
    wr(A_DET_WID, 32'h0a);
    funcs(6'h04, 6'h05, 6'h03);
    fstep(16'h69, 3'b110);
    fstep(16'h6f, 3'b001);
    fstep(16'h69, 3'b101);
    fstep(16'h63, 3'b110);
    fstep(16'h59, 3'b010);
    wr(A_FMIN, 32'h96);
    @(posedge pclk);
    freq_ref <= 16'hc8;
    funcs(6'h02, 6'h14, 6'h00);
    fstep(16'hbe, 3'b111);
    fstep(16'hbd, 3'b110);
    fstep(16'h96, 3'b100);
    fstep(16'hc9, 3'b110);
    fstep(16'h0, 3'b000);
    wr(A_UV_LVL, 32'h64);
    wr(A_CUR_THR, 32'h32);
    wr(A_CUR_TIME, 32'h2);
    funcs(6'h16, 6'h0d, 6'h20);
    @(posedge pclk);
    dc_bus <= 16'h63;
    current <= 16'h3c;
    settle();
    chk("uv_cur", 32'(dout), 32'h1);
    n = 0;
    while (dout[1] !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    // not on at exactly 2 ms, on within the next ms plus pipeline
    chk("cur_on", 32'(n > 2 && n < 12), 32'h1);
    @(posedge pclk);
    dc_bus <= 16'h64;
    current <= 16'h28;
    settle();
    chk("uv_cur", 32'(dout), 32'h0);
    wr(A_RUN_SRC, 32'h1);
    wr(A_REF_SRC, 32'h2);
    funcs(6'h17, 6'h18, 6'h12);
    settle();
    chk("remote", 32'({ref_lamp, run_lamp, dout}), 32'h18);
    rd("status", A_STATUS, 32'h60);
    @(posedge pclk);
    fl <= 18'h00400;
    settle();
    chk("local", 32'({ref_lamp, run_lamp, dout}), 32'h03);
    @(posedge pclk);
    fl <= 18'h0;
    wr(A_RUN_SRC, 32'h3);
    settle();
    chk("plc_src", 32'(dout), 32'h4);
    // bits two and three set before the gate opens
    wr(A_RELAY, 32'h7);
    funcs(6'h20, 6'h20, 6'h20);
    settle();
    chk("relay_gate", 32'(dout), 32'h1);
    // host word 5 opens the gate of relay bits two and three
    wr(A_RELAY, 32'h5);
    settle();
    chk("relay5", 32'(dout), 32'h5);
    wr(A_RELAY, 32'h4);
    settle();
    chk("relay4", 32'(dout), 32'h0);
    wr(A_RELAY, 32'h7);
    settle();
    chk("relay7", 32'(dout), 32'h1);
    wr(A_RELAY, 32'h5);
    settle();
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk("rst_out", 32'({l_resp, dout}), 32'h0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("func_c", A_FUNC_C, 32'h3f);
    rd("relay", A_RELAY, 32'h0);
    finish_test();
  end
endmodule
